/* hw/dhp_pkg.sv */
// dhp_pkg: constants of the display host port.
// assumes one 50 MHz clock; pins idle high through pull-ups, the enable strobe idles low.
// Operation
// - parallel items move as byte or two nibbles
// - nibbles high first on upper four lines
// - select line low instruction, high data
// - enable mode writes on strobe falling edge
// - enable mode reads drive after strobe rise
// - strobe mode writes on write strobe rise
// - strobe mode reads drive after read fall
// - serial frame is two bytes, MSB first
// - header direction one reads, zero writes
// - header select zero instruction, one data
// - serial input sampled on rising clock
// - read waits 1 us, bits after falls
// - frame strobe low frames; unclosed frames discarded
// - power-up reset; pin reset only in parallel
// - display counter steps and wraps at gaps
// - glyph counter steps, wraps 3F and 00
// - display address is the cursor position
// - display addresses only in two ranges
// - busy flag always reads zero
package dhp_pkg;
    localparam logic [1:0] MODE_M68 = 2'h0;
    localparam logic [1:0] MODE_I80 = 2'h1;
    localparam logic [1:0] MODE_SER = 2'h2;
    localparam logic [6:0] DD_L0_BEG = 7'h00;
    localparam logic [6:0] DD_L0_END = 7'h27;
    localparam logic [6:0] DD_L1_BEG = 7'h40;
    localparam logic [6:0] DD_L1_END = 7'h67;
    localparam logic [5:0] GL_BEG    = 6'h00;
    localparam logic [5:0] GL_END    = 6'h3F;
    localparam logic [7:0] INS_CLEAR = 8'h01;
    localparam logic [6:0] INS_HOME  = 7'h01;
    localparam logic [5:0] INS_ENTRY = 6'h01;
    localparam logic [1:0] INS_GLY   = 2'h1;
    localparam int         ENTRY_ID  = 1;
    localparam int         BUSY_BIT  = 7;
    localparam logic [4:0] HDR_ONES  = 5'h1F;
    localparam int         HDR_DIR   = 2;
    localparam int         HDR_RS    = 1;
    localparam logic [4:0] SER_BYTE  = 5'h08;
    localparam logic [4:0] SER_FRAME = 5'h10;
    localparam logic [6:0] AC_RST    = 7'h00;
    localparam logic       INC_RST   = 1'b1;
    localparam logic [19:0] PIN_RST  = 20'hF7FFF;
    localparam int         CLK_NS    = 20;
    localparam int         T_DD_NS   = 150;
    localparam int         DD_CYC    = (T_DD_NS / CLK_NS) < 1 ? 1 : T_DD_NS / CLK_NS;
endpackage

/* hw/dhp_ser_if.sv */
// dhp_ser_if: serial engine to core transfer signals.
// assumes both ends on the same clock.
`timescale 1ns/100ps
interface dhp_ser_if;
    logic       wr_ev;
    logic       rd_req;
    logic       rd_end;
    logic       rs;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    modport ser  (output wr_ev, rd_req, rd_end, rs, wbyte, input rbyte);
    modport core (input wr_ev, rd_req, rd_end, rs, wbyte, output rbyte);
endinterface

/* hw/dhp_serial.sv */
// dhp_serial: strobe-framed two byte serial engine.
// assumes synchronised pin levels; rbyte stable during the wait.
`timescale 1ns/100ps
module dhp_serial (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic en,
    input  wire logic s_sck,
    input  wire logic s_stb,
    input  wire logic s_si,
    dhp_ser_if.ser    bus,
    output logic      so_q,
    output logic      so_oe_n_q
);
    logic       sck_p_q, stb_p_q, act_q;
    logic [4:0] cnt_q;
    logic [7:0] hdr_q, dat_q, tx_q;
    wire        sck_rise = s_sck & ~sck_p_q;
    wire        sck_fall = ~s_sck & sck_p_q;
    wire        stb_rise = s_stb & ~stb_p_q;
    wire        stb_fall = ~s_stb & stb_p_q;
    wire [7:0]  hdr_nx   = {hdr_q[6:0], s_si};
    wire        hdr_ok   = hdr_q[7:3] == dhp_pkg::HDR_ONES && !hdr_q[0];
    wire        nx_ok    = hdr_nx[7:3] == dhp_pkg::HDR_ONES && !hdr_nx[0];
    wire        is_rd    = hdr_q[dhp_pkg::HDR_DIR];
    wire        shift_in = sck_rise && cnt_q != dhp_pkg::SER_FRAME;
    wire        first_tx = cnt_q == dhp_pkg::SER_BYTE;
    wire        tx_go    = sck_fall && is_rd && cnt_q >= dhp_pkg::SER_BYTE;
    wire [7:0]  tx_src   = first_tx ? bus.rbyte : tx_q;
    wire        closed   = act_q && cnt_q == dhp_pkg::SER_FRAME && hdr_ok;

    // frame tracking; a frame counts only when the strobe closes it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {sck_p_q, stb_p_q, act_q} <= 3'h6;
            {cnt_q, hdr_q, dat_q, tx_q} <= 29'h0;
            {bus.wr_ev, bus.rd_req, bus.rd_end, bus.rs} <= 4'h0;
            bus.wbyte <= 8'h00;
            so_q      <= 1'b1;
            so_oe_n_q <= 1'b1;
        end else begin
            sck_p_q    <= s_sck;
            stb_p_q    <= s_stb;
            bus.wr_ev  <= 1'b0;
            bus.rd_req <= 1'b0;
            bus.rd_end <= 1'b0;
            if (!en || stb_fall || stb_rise) begin
                act_q     <= en && stb_fall;
                cnt_q     <= 5'h00;
                so_oe_n_q <= 1'b1;
                bus.wr_ev  <= en && stb_rise && closed && !is_rd;
                bus.rd_end <= en && stb_rise && closed && is_rd;
                bus.wbyte  <= dat_q;
            end else if (act_q) begin
                if (shift_in) begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q < dhp_pkg::SER_BYTE) hdr_q <= hdr_nx;
                    else if (!is_rd) dat_q <= {dat_q[6:0], s_si};
                end
                if (shift_in && cnt_q == dhp_pkg::SER_BYTE - 5'h01) begin
                    bus.rd_req <= nx_ok && hdr_nx[dhp_pkg::HDR_DIR];
                    bus.rs     <= hdr_nx[dhp_pkg::HDR_RS];
                end
                // in a read frame, one bit after each data falling edge
                if (tx_go) begin
                    so_oe_n_q <= 1'b0;
                    so_q      <= tx_src[7];
                    tx_q      <= {tx_src[6:0], 1'b0};
                end
            end
        end
    end

    a_ser_discard: assert property (@(posedge clk) disable iff (!nrst)
        stb_rise && cnt_q != dhp_pkg::SER_FRAME |=> !bus.wr_ev && !bus.rd_end)
        else $error("unclosed serial frame accepted");
    // serial line released outside a frame
    a_ser_release: assert property (@(posedge clk) disable iff (!nrst)
        stb_rise |=> so_oe_n_q)
        else $error("serial output still driven after frame");
endmodule

/* hw/dhp_top.sv */
// dhp_top: display host port, parallel and serial links with address counter.
// assumes pins asynchronous to clk; display memory outside reads at address_counter.
`timescale 1ns/100ps
module dhp_top (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [1:0] mode_sel,
    input  wire logic       bus_nibble,
    input  wire logic       ext_rst_n,
    input  wire logic       e_strobe,
    input  wire logic       rw_dir,
    input  wire logic       wr_n,
    input  wire logic       rd_n,
    input  wire logic       cmd_data_select,
    input  wire logic [7:0] data_lines_in,
    output logic      [7:0] data_lines_out,
    output logic            data_lines_oe_n,
    input  wire logic       sck,
    input  wire logic       frame_strobe,
    input  wire logic       serial_io_in,
    output logic            serial_io_out,
    output logic            serial_io_oe_n,
    input  wire logic [7:0] mem_rdata,
    output logic            mem_we,
    output logic            mem_glyph,
    output logic      [6:0] mem_addr,
    output logic      [7:0] mem_wdata,
    output logic      [6:0] address_counter,
    output logic            glyph_sel,
    output logic      [6:0] cursor_pos
);
    localparam int DD_CYC = dhp_pkg::DD_CYC;

    // one step of the counter, wrapping over the gaps between ranges
    function automatic logic [6:0] ac_step(input logic [6:0] a,
                                           input logic       gl,
                                           input logic       up);
        logic [6:0] r;
        r = a;
        if (gl) begin
            if (up) r = (a[5:0] == dhp_pkg::GL_END) ? {1'b0, dhp_pkg::GL_BEG}
                                                    : {1'b0, a[5:0] + 6'h01};
            else    r = (a[5:0] == dhp_pkg::GL_BEG) ? {1'b0, dhp_pkg::GL_END}
                                                    : {1'b0, a[5:0] - 6'h01};
        end else if (up) begin
            if (a == dhp_pkg::DD_L0_END)      r = dhp_pkg::DD_L1_BEG;
            else if (a == dhp_pkg::DD_L1_END) r = dhp_pkg::DD_L0_BEG;
            else                              r = a + 7'h01;
        end else begin
            if (a == dhp_pkg::DD_L1_BEG)      r = dhp_pkg::DD_L0_END;
            else if (a == dhp_pkg::DD_L0_BEG) r = dhp_pkg::DD_L1_END;
            else                              r = a - 7'h01;
        end
        return r;
    endfunction

    // display address inside one of the two valid ranges
    function automatic logic dd_valid(input logic [6:0] a);
        return a <= dhp_pkg::DD_L0_END ||
               (a >= dhp_pkg::DD_L1_BEG && a <= dhp_pkg::DD_L1_END);
    endfunction

    // every pin passes two flops; reset value is the pin's idle level, so no false edge
    logic [19:0] pin_raw, meta_q, sync_q, prev_q;
    assign pin_raw = {mode_sel, bus_nibble, ext_rst_n, e_strobe, rw_dir, wr_n, rd_n,
                      sck, frame_strobe, serial_io_in, cmd_data_select, data_lines_in};

    genvar gi;
    generate
        for (gi = 0; gi < 20; gi++) begin : g_sync
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    meta_q[gi] <= dhp_pkg::PIN_RST[gi];
                    sync_q[gi] <= dhp_pkg::PIN_RST[gi];
                end else begin
                    meta_q[gi] <= pin_raw[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    // previous synchronised level, for edge detection
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) prev_q <= dhp_pkg::PIN_RST;
        else       prev_q <= sync_q;
    end

    // synchronised levels; data and strobes share latency so they stay aligned
    wire [1:0] s_mode = sync_q[19:18];
    wire       s_nib  = sync_q[17];
    wire       s_xrst = sync_q[16];
    wire       s_e    = sync_q[15];
    wire       s_rw   = sync_q[14];
    wire       s_wr   = sync_q[13];
    wire       s_rd   = sync_q[12];
    wire       s_sck  = sync_q[11];
    wire       s_stb  = sync_q[10];
    wire       s_si   = sync_q[9];
    wire       s_rs   = sync_q[8];
    wire [7:0] s_din  = sync_q[7:0];
    wire       e_rise  = s_e & ~prev_q[15];
    wire       e_fall  = ~s_e & prev_q[15];
    wire       wr_rise = s_wr & ~prev_q[13];
    wire       rd_fall = ~s_rd & prev_q[12];
    wire       rd_rise = s_rd & ~prev_q[12];

    // link selection from the jumpers; code 3 selects no link
    wire is_m68 = s_mode == dhp_pkg::MODE_M68;
    wire is_i80 = s_mode == dhp_pkg::MODE_I80;
    wire is_ser = s_mode == dhp_pkg::MODE_SER;

    // pin reset acts only with a parallel link
    wire soft_rst = (is_m68 || is_i80) && !s_xrst;

    wire m68_wr  = is_m68 && e_fall && !s_rw;
    wire m68_rdb = is_m68 && e_rise && s_rw;
    wire m68_rde = is_m68 && e_fall && s_rw;
    wire i80_wr  = is_i80 && wr_rise;
    wire i80_rdb = is_i80 && rd_fall;
    wire i80_rde = is_i80 && rd_rise;
    wire p_wr    = m68_wr || i80_wr;
    wire p_rdb   = m68_rdb || i80_rdb;
    wire p_rde   = m68_rde || i80_rde;

    // core state
    logic [6:0] ac_q;
    logic       glyph_q, inc_q, nib_q, drv_q;
    logic [3:0] hi_q;
    logic [7:0] rbyte_q;
    dhp_ser_if  sif ();

    // second nibble completes the item; low lines ignored
    wire       last_half = !s_nib || nib_q;
    wire [7:0] p_byte    = s_nib ? {hi_q, s_din[7:4]} : s_din;

    // merged transfer events of whichever link is selected
    wire       wr_ev   = (p_wr && last_half) || sif.wr_ev;
    wire       rd_done = (p_rde && last_half) || sif.rd_end;
    wire       ev_rs   = is_ser ? sif.rs : s_rs;
    wire [7:0] wr_byte = is_ser ? sif.wbyte : p_byte;

    // select line splits instructions from data
    wire ins_wr   = wr_ev && !ev_rs;
    wire dat_step = (wr_ev || rd_done) && ev_rs;

    // instruction decode
    wire ins_home  = wr_byte == dhp_pkg::INS_CLEAR || wr_byte[7:1] == dhp_pkg::INS_HOME;
    wire ins_entry = wr_byte[7:2] == dhp_pkg::INS_ENTRY;
    wire ins_gly   = wr_byte[7:6] == dhp_pkg::INS_GLY;
    wire ins_dd    = wr_byte[7];

    wire [6:0] ac_stepped = ac_step(ac_q, glyph_q, inc_q);
    // out-of-range display address set is ignored
    wire dd_ok = dd_valid(wr_byte[6:0]);
    wire [6:0] ac_d = (ins_wr && ins_home)          ? dhp_pkg::AC_RST :
                      (ins_wr && ins_gly)           ? {1'b0, wr_byte[5:0]} :
                      (ins_wr && ins_dd && dd_ok)   ? wr_byte[6:0] :
                      dat_step                      ? ac_stepped : ac_q;
    wire glyph_d = (ins_wr && (ins_home || (ins_dd && dd_ok))) ? 1'b0 :
                   (ins_wr && ins_gly)                          ? 1'b1 : glyph_q;

    // status read: busy zero beside the counter
    wire [7:0] rd_val = ev_rs ? mem_rdata : {1'b0, ac_q};
    wire [7:0] p_out  = !s_nib ? rd_val :
                        nib_q  ? {rbyte_q[3:0], 4'h0} : {rd_val[7:4], 4'h0};

    // counter, mode and direction state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ac_q    <= dhp_pkg::AC_RST;
            glyph_q <= 1'b0;
            inc_q   <= dhp_pkg::INC_RST;
        end else if (soft_rst) begin
            ac_q    <= dhp_pkg::AC_RST;
            glyph_q <= 1'b0;
            inc_q   <= dhp_pkg::INC_RST;
        end else begin
            ac_q    <= ac_d;
            glyph_q <= glyph_d;
            // entry mode sets the step direction
            if (ins_wr && ins_entry) inc_q <= wr_byte[dhp_pkg::ENTRY_ID];
        end
    end

    // nibble phase and read value holding
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nib_q   <= 1'b0;
            hi_q    <= 4'h0;
            rbyte_q <= 8'h00;
        end else if (soft_rst) begin
            nib_q   <= 1'b0;
            hi_q    <= 4'h0;
        end else begin
            if (s_nib && (p_wr || p_rde)) nib_q <= !nib_q;
            if (p_wr && !nib_q) hi_q <= s_din[7:4];
            if (sif.rd_req || (p_rdb && !nib_q)) rbyte_q <= rd_val;
        end
    end
    assign sif.rbyte = rbyte_q;

    // data lines driven only during a read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            drv_q           <= 1'b0;
            data_lines_out  <= 8'h00;
            data_lines_oe_n <= 1'b1;
        end else if (soft_rst || p_rde || !(is_m68 || is_i80)) begin
            drv_q           <= 1'b0;
            data_lines_oe_n <= 1'b1;
        end else if (p_rdb) begin
            drv_q           <= 1'b1;
            data_lines_out  <= p_out;
            data_lines_oe_n <= 1'b0;
        end
    end

    // memory write port and visible counter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_we          <= 1'b0;
            mem_glyph       <= 1'b0;
            mem_addr        <= 7'h00;
            mem_wdata       <= 8'h00;
            address_counter <= dhp_pkg::AC_RST;
            glyph_sel       <= 1'b0;
            cursor_pos      <= dhp_pkg::AC_RST;
        end else begin
            mem_we          <= wr_ev && ev_rs && !soft_rst;
            mem_glyph       <= glyph_q;
            mem_addr        <= ac_q;
            mem_wdata       <= wr_byte;
            address_counter <= ac_q;
            glyph_sel       <= glyph_q;
            // cursor follows the counter in display memory
            if (!glyph_q) cursor_pos <= ac_q;
        end
    end

    // serial engine; its outputs are its own flops
    dhp_serial u_ser (
        .clk       (clk),
        .nrst      (nrst),
        .en        (is_ser),
        .s_sck     (s_sck),
        .s_stb     (s_stb),
        .s_si      (s_si),
        .bus       (sif.ser),
        .so_q      (serial_io_out),
        .so_oe_n_q (serial_io_oe_n)
    );

    a_dd_up_wrap: assert property (@(posedge clk) disable iff (!nrst)
        dat_step && !soft_rst && !glyph_q && inc_q && ac_q == dhp_pkg::DD_L0_END
        |=> ac_q == dhp_pkg::DD_L1_BEG)
        else $error("display counter missed wrap 27 to 40");
    a_dd_dn_wrap: assert property (@(posedge clk) disable iff (!nrst)
        dat_step && !soft_rst && !glyph_q && !inc_q && ac_q == dhp_pkg::DD_L0_BEG
        |=> ac_q == dhp_pkg::DD_L1_END)
        else $error("display counter missed wrap 00 to 67");
    a_gl_up_wrap: assert property (@(posedge clk) disable iff (!nrst)
        dat_step && !soft_rst && glyph_q && inc_q && ac_q[5:0] == dhp_pkg::GL_END
        |=> ac_q == 7'h00 && glyph_q)
        else $error("glyph counter missed wrap 3F to 00");
    a_dd_range: assert property (@(posedge clk) disable iff (!nrst)
        !glyph_q |-> dd_valid(ac_q))
        else $error("display address outside valid ranges");
    // enable fall with write direction stores a byte
    a_m68_write: assert property (@(posedge clk) disable iff (!nrst)
        m68_wr && !s_nib && s_rs && !soft_rst |=> mem_we && mem_wdata == $past(s_din))
        else $error("enable-strobed write not captured");
    // read strobe fall drives the lines within the delay
    sequence s_rd_drive;
        ##[1:DD_CYC] !data_lines_oe_n;
    endsequence
    a_i80_read: assert property (@(posedge clk) disable iff (!nrst)
        i80_rdb && !soft_rst |-> s_rd_drive)
        else $error("read strobe did not drive data lines");
    a_busy_zero: assert property (@(posedge clk) disable iff (!nrst)
        p_rdb && !s_rs && !s_nib && !soft_rst |=> !data_lines_out[dhp_pkg::BUSY_BIT])
        else $error("busy flag read as one");
    // lines released when no read is running
    a_par_release: assert property (@(posedge clk) disable iff (!nrst)
        !drv_q |-> data_lines_oe_n)
        else $error("data lines driven outside a read");
    // pin reset clears the counter in parallel modes
    a_pin_reset: assert property (@(posedge clk) disable iff (!nrst)
        soft_rst [*2] |-> ac_q == dhp_pkg::AC_RST && !glyph_q && inc_q)
        else $error("pin reset did not clear counter");
endmodule

/* test/dhp_host_model.sv */
// dhp_host_model: host side of the display port, parallel and serial links.
// assumes released lines float high through pull-ups; mode and width come from the bench.
`timescale 1ns/100ps
module dhp_host_model (
    input  wire logic       clk,
    input  wire logic [1:0] mode,
    input  wire logic       nib,
    output logic            e_strobe,
    output logic            rw_dir,
    output logic            wr_n,
    output logic            rd_n,
    output logic            cmd_data_select,
    output logic      [7:0] data_lines_in,
    input  wire logic [7:0] data_lines_out,
    input  wire logic       data_lines_oe_n,
    output logic            sck,
    output logic            frame_strobe,
    output logic            serial_io_in,
    input  wire logic       serial_io_out,
    input  wire logic       serial_io_oe_n
);
    logic [7:0] dq;
    logic       dq_en;
    logic       si;
    logic       si_en;

    // wire level: device first, then host, else the pull-up
    assign data_lines_in = !data_lines_oe_n ? data_lines_out : (dq_en ? dq : 8'hFF);
    assign serial_io_in  = !serial_io_oe_n ? serial_io_out : (si_en ? si : 1'b1);

    // idle pins; serial clock stands high outside frames
    initial begin
        {e_strobe, rw_dir, dq_en, si_en, dq, si} = '0;
        {wr_n, rd_n, sck, frame_strobe, cmd_data_select} = '1;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one strobe; levels held well past the pin sync latency
    // select line qualifies the item
    task automatic cyc(input logic rd, input logic rs, input logic [7:0] v,
                       output logic [7:0] q);
        cmd_data_select <= rs;
        rw_dir          <= rd;
        dq              <= v;
        dq_en           <= !rd;
        wt(3);
        if (mode == 2'h0) e_strobe <= 1'b1;
        else if (rd) rd_n <= 1'b0;
        else wr_n <= 1'b0;
        wt(7);
        @(negedge clk) q = data_lines_in;
        @(posedge clk);
        e_strobe <= 1'b0;
        wr_n     <= 1'b1;
        rd_n     <= 1'b1;
        wt(3);
        dq_en <= 1'b0;
        wt(5);
    endtask

    // nibbles high first on the upper lines, junk below
    task automatic par(input logic rd, input logic rs, input logic [7:0] v,
                       output logic [7:0] q);
        logic [7:0] h;
        logic [7:0] l;
        if (nib) begin
            cyc(rd, rs, {v[7:4], 4'h5}, h);
            cyc(rd, rs, {v[3:0], 4'hA}, l);
            q = {h[7:4], l[7:4]};
        end else begin
            cyc(rd, rs, v, q);
        end
    endtask

    // header then item, MSB first, framed by the strobe
    task automatic ser(input logic [7:0] hdr, input logic [7:0] v, input int nb,
                       output logic [7:0] q);
        q = 8'h00;
        frame_strobe <= 1'b0;
        si_en        <= 1'b1;
        wt(4);
        for (int i = 0; i < nb; i++) begin
            // gap after the header, line released for a read
            if (i == 8) begin
                si_en <= !hdr[2];
                wt(50);
            end
            sck <= 1'b0;
            si  <= (i < 8) ? hdr[7-i] : v[15-i];
            wt(4);
            sck <= 1'b1;
            wt(3);
            @(negedge clk) if (i >= 8) q[15-i] = serial_io_in;
            @(posedge clk);
        end
        wt(4);
        frame_strobe <= 1'b1;
        si_en        <= 1'b0;
        wt(10);
    endtask
endmodule

/* test/tb_top.sv */
// tb_top: host port bench; same sequence over every link and width.
// assumes display memory returns {1, counter} at the counter address.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    logic       clk, nrst, bus_nibble, ext_rst_n, e_s, rw, wr_n, rd_n, rs, sck, stb, sin;
    logic       oe_n, so, so_oe_n, we, gl, gsel, w_gl;
    logic [1:0] mode_sel;
    logic [7:0] din, dout, wdat, w_dat, q;
    logic [6:0] maddr, ac, cur, w_addr;
    int         fail_count, check_count, we_n, we_0;
    logic [2:0] cfg [5] = '{3'h0, 3'h3, 3'h4, 3'h1, 3'h2};

    dhp_top i_dut (.clk(clk), .nrst(nrst), .mode_sel(mode_sel), .bus_nibble(bus_nibble),
        .ext_rst_n(ext_rst_n), .e_strobe(e_s), .rw_dir(rw), .wr_n(wr_n), .rd_n(rd_n),
        .cmd_data_select(rs), .data_lines_in(din), .data_lines_out(dout),
        .data_lines_oe_n(oe_n), .sck(sck), .frame_strobe(stb), .serial_io_in(sin),
        .serial_io_out(so), .serial_io_oe_n(so_oe_n), .mem_rdata({1'b1, ac}), .mem_we(we),
        .mem_glyph(gl), .mem_addr(maddr), .mem_wdata(wdat), .address_counter(ac),
        .glyph_sel(gsel), .cursor_pos(cur));
    dhp_host_model i_host (.clk(clk), .mode(mode_sel), .nib(bus_nibble), .e_strobe(e_s),
        .rw_dir(rw), .wr_n(wr_n), .rd_n(rd_n), .cmd_data_select(rs), .data_lines_in(din),
        .data_lines_out(dout), .data_lines_oe_n(oe_n), .sck(sck), .frame_strobe(stb),
        .serial_io_in(sin), .serial_io_out(so), .serial_io_oe_n(so_oe_n));

    // record each memory write the port issues
    always @(posedge clk) begin
        if (we === 1'b1) begin
            we_n   <= we_n + 1;
            w_addr <= maddr;
            w_dat  <= wdat;
            w_gl   <= gl;
        end
    end

    task automatic give_verdict;
        if (fail_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic put(input logic c, input logic [7:0] v);
        logic [7:0] r;
        if (mode_sel == 2'h2) i_host.ser({5'h1F, 1'b0, c, 1'b0}, v, 16, r);
        else i_host.par(1'b0, c, v, r);
    endtask
    task automatic get(input logic c, output logic [7:0] r);
        if (mode_sel == 2'h2) i_host.ser({5'h1F, 1'b1, c, 1'b0}, 8'h00, 16, r);
        else i_host.par(1'b1, c, 8'h00, r);
    endtask
    // data write: one store at the old counter, then the step
    task automatic putd(input logic [6:0] a, input logic g, input logic [7:0] v,
                        input logic [6:0] nx);
        int n0;
        n0 = we_n;
        put(1'b1, v);
        `CHK("store count", n0 + 1, we_n)
        `CHK("mem_addr", a, w_addr)
        `CHK("mem_wdata", v, w_dat)
        `CHK("mem_glyph", g, w_gl)
        `CHK("address_counter", nx, ac)
        `CHK("glyph_sel", g, gsel)
        if (!g) `CHK("cursor_pos", nx, cur)
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
    // main sequence
    initial begin
        {nrst, mode_sel, bus_nibble, fail_count, check_count, we_n} = '0;
        ext_rst_n = 1'b1;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("reset lines", 1'b1, oe_n & so_oe_n)
        `CHK("reset counter", 7'h00, ac)
        repeat (5000) @(posedge clk);
        for (int k = 0; k < 5; k++) begin
            mode_sel   <= cfg[k][2:1];
            bus_nibble <= cfg[k][0];
            repeat (10) @(posedge clk);
            put(1'b0, 8'h01);
            `CHK("clear", 7'h00, ac)
            put(1'b0, 8'hA7);
            putd(7'h27, 1'b0, 8'h31, 7'h40);
            put(1'b0, 8'hE7);
            putd(7'h67, 1'b0, 8'h32, 7'h00);
            put(1'b0, 8'h04);
            putd(7'h00, 1'b0, 8'h33, 7'h67);
            put(1'b0, 8'hC0);
            putd(7'h40, 1'b0, 8'h34, 7'h27);
            put(1'b0, 8'h40);
            putd(7'h00, 1'b1, 8'h35, 7'h3F);
            put(1'b0, 8'h06);
            putd(7'h3F, 1'b1, 8'h36, 7'h00);
            put(1'b0, 8'h85);
            put(1'b0, 8'hAA);
            get(1'b0, q);
            `CHK("instr read", 8'h05, q)
            get(1'b1, q);
            `CHK("data read", 8'h85, q)
            `CHK("read step", 7'h06, ac)
            `CHK("lines released", 1'b1, oe_n & so_oe_n)
        end
        mode_sel <= 2'h2;
        repeat (10) @(posedge clk);
        put(1'b0, 8'h85);
        we_0 = we_n;
        i_host.ser(8'hFA, 8'h77, 12, q);
        i_host.ser(8'hF2, 8'h77, 16, q);
        `CHK("refused frames", 7'h05, ac)
        `CHK("refused stores", we_0, we_n)
        ext_rst_n <= 1'b0;
        repeat (30) @(posedge clk);
        ext_rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK("serial pin reset", 7'h05, ac)
        mode_sel <= 2'h0;
        repeat (10) @(posedge clk);
        ext_rst_n <= 1'b0;
        repeat (30) @(posedge clk);
        ext_rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK("parallel pin reset", 7'h00, ac)
        give_verdict();
    end
endmodule
